// ### shared/pfpp_defs.vh
// pfpp_defs.vh: constants of the parallel flash programming port
// assumes: included by bare name from the design files
`ifndef PFPP_DEFS_VH
`define PFPP_DEFS_VH
// field selector codes
`define PFPP_SEL_CMD        4'h0
`define PFPP_SEL_ADDR_LO    4'h1
`define PFPP_SEL_ADDR_HI    4'h2
`define PFPP_SEL_DATA       4'h5
// command codes
`define PFPP_CMD_READ       16'h0011
`define PFPP_CMD_WP         16'h0012
`define PFPP_CMD_WPP        16'h0022
`define PFPP_CMD_EWP        16'h0032
`define PFPP_CMD_EWPP       16'h0042
`define PFPP_CMD_ERASE      16'h0013
`define PFPP_CMD_SETLK      16'h0014
`define PFPP_CMD_CLRLK      16'h0024
`define PFPP_CMD_GETLK      16'h0015
`define PFPP_CMD_SETSEC     16'h0054
`define PFPP_CMD_GETSEC     16'h0035
`define PFPP_CMD_SETNV      16'h0034
`define PFPP_CMD_CLRNV      16'h0044
`define PFPP_CMD_GETNV      16'h0025
`define PFPP_CMD_RAM_WRITE_CMD       16'h001f
`define PFPP_CMD_SELFC      16'h0016
`define PFPP_CMD_VERSION    16'h001e
// command class codes driven to the flash side
`define PFPP_OP_NONE        4'h0
`define PFPP_OP_READ        4'h1
`define PFPP_OP_WP          4'h2
`define PFPP_OP_WPP         4'h3
`define PFPP_OP_EWP         4'h4
`define PFPP_OP_EWPP        4'h5
`define PFPP_OP_ERASE       4'h6
`define PFPP_OP_SETLK       4'h7
`define PFPP_OP_CLRLK       4'h8
`define PFPP_OP_GETLK       4'h9
`define PFPP_OP_SETSEC      4'ha
`define PFPP_OP_GETSEC      4'hb
`define PFPP_OP_SETNV       4'hc
`define PFPP_OP_CLRNV       4'hd
`define PFPP_OP_GETNV       4'he
`define PFPP_OP_OTHER       4'hf
// clock detect: least external frequency and internal clock, in kHz
`define PFPP_EXT_MIN_KHZ    32
`define PFPP_CLK_KHZ        25000
// internal clock cycles in one period of the least external clock
`define PFPP_EXT_WIN_CYC    (`PFPP_CLK_KHZ / `PFPP_EXT_MIN_KHZ)
`endif

// ### design/pfpp_buf2.v
// pfpp_buf2.v: two-entry buffer with valid/ready on both sides
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
module pfpp_buf2 #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] spare_r;
    reg             head_ok_r;
    reg             spare_ok_r;

    assign in_ready  = ~spare_ok_r;
    assign out_valid = head_ok_r;

    // =========================================
    // head register feeds out, spare catches a stall
    always @(posedge clk) begin
        if (!rst_b) begin
            head_ok_r  <= 1'b0;
            spare_ok_r <= 1'b0;
            out_data   <= {WIDTH{1'b0}};
            spare_r    <= {WIDTH{1'b0}};
        end else begin
            if (!head_ok_r || out_ready) begin
                if (spare_ok_r) begin
                    out_data   <= spare_r;
                    head_ok_r  <= 1'b1;
                    spare_ok_r <= 1'b0;
                end else begin
                    out_data  <= in_data;
                    head_ok_r <= in_valid;
                end
            end else if (in_valid && !spare_ok_r) begin
                spare_r    <= in_data; // head stalled, park word
                spare_ok_r <= 1'b1;
            end
        end
    end
endmodule

// ### design/pfpp_port.v
// pfpp_port.v: parallel flash programming port, device end
// assumes: pins arrive unsynchronised; flash side is same-clock logic
// Overview of operation
// [RQ1] selector picks command, address low/high, data
// [RQ2] command select stores full 16-bit word
// [RQ3] codes for read, program, program-and-protect
// [RQ4] codes for erase-program, erase-program-protect
// [RQ5] codes for erase, protect, secure bit
// [RQ6] codes for nv bits, ram, controller, version
// [RQ7] programmer strobes only while ready high
// [RQ8] handshake ends with strobe high, ready high
// [RQ9] programmer sets selector, data before strobe
// [RQ10] falling strobe latches inputs, then ready drops
// [RQ11] programmer releases bus, raises strobe
// [RQ12] execute, wait strobe high, then raise ready
// [RQ13] ready low while busy, high when free
// [RQ14] switch to external clock if above 32 kHz
// [RQ15] clock pin may be grounded, up to 50MHz
// [RQ16] programmer ties test selects high
// [RQ17] programmer clocks within reset, then handshakes
// [RQ18] all port pins are inputs at reset
// [RQ19] read: drive data, valid low, until enable high
// [RQ20] chained data transfers bump the address
// [RQ21] new command first finishes the previous one
// [RQ22] idle selector completes handshake, changes nothing
`timescale 1ns/1ps
`include "pfpp_defs.vh"
module pfpp_port #(
    parameter EXT_WIN = `PFPP_EXT_WIN_CYC
) (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RST_B,
    // test mode selects
    input  wire        TEST_SELECT,
    input  wire        PROG_SELECT_0,
    input  wire        PROG_SELECT_1,
    input  wire        MAIN_CLK_IN,
    output reg         EXT_CLK_SEL,
    // handshake pins
    input  wire        CMD_STROBE_N,
    output reg         READY_OUT,
    output reg         READY_OE,
    input  wire        OUT_ENABLE_N,
    output reg         DATA_VALID_N,
    output reg         DATA_VALID_OE,
    input  wire [3:0]  FIELD_SELECT,
    // data bus, three signals
    input  wire [15:0] PROG_DATA_IN,
    output reg  [15:0] PROG_DATA_OUT,
    output reg         PROG_DATA_OE,
    // flash side command and address
    output reg  [15:0] CMD_WORD,
    output reg  [3:0]  CMD_OP,
    output reg  [31:0] FLASH_ADDR,
    output reg         CMD_START,
    output reg         FLUSH_REQ,
    input  wire        FLASH_BUSY,
    // flash side write words
    output wire        WR_VALID,
    input  wire        WR_READY,
    output wire [15:0] WR_DATA,
    // flash side read words
    output reg         RD_REQ,
    input  wire        RD_ACK,
    input  wire [15:0] RD_DATA
);
    localparam S_IDLE  = 6'h01;
    localparam S_EXEC  = 6'h02;
    localparam S_WAITO = 6'h04;
    localparam S_FETCH = 6'h08;
    localparam S_DRIVE = 6'h10;
    localparam S_WAITS = 6'h20;

    // pin synchronisers, first stage read only by second
    reg [25:0] meta_r;
    reg [25:0] sync_r;
    wire       strobe_n = sync_r[0];
    wire       oe_n     = sync_r[1];
    wire       mode_on  = &sync_r[4:2]; // [RQ16]
    wire       main_clk_in      = sync_r[5];
    wire [3:0] sel      = sync_r[9:6];
    wire [15:0] din     = sync_r[25:10];

    reg [5:0]  state_r;
    reg [3:0]  sel_r;
    reg [15:0] word_r;
    reg [15:0] addr_hi_r;
    reg        xin_d_r;
    reg [15:0] win_r;
    reg [1:0]  edges_r;
    reg        det_done_r;
    reg        wr_push_r;
    wire       wr_in_ready;

    // =========================================
    // command code to class
    function [3:0] cmd_class;
        input [15:0] c;
        begin
            case (c)
                `PFPP_CMD_READ:    cmd_class = `PFPP_OP_READ;   // [RQ3]
                `PFPP_CMD_WP:      cmd_class = `PFPP_OP_WP;     // [RQ3]
                `PFPP_CMD_WPP:     cmd_class = `PFPP_OP_WPP;    // [RQ3]
                `PFPP_CMD_EWP:     cmd_class = `PFPP_OP_EWP;    // [RQ4]
                `PFPP_CMD_EWPP:    cmd_class = `PFPP_OP_EWPP;   // [RQ4]
                `PFPP_CMD_ERASE:   cmd_class = `PFPP_OP_ERASE;  // [RQ5]
                `PFPP_CMD_SETLK:   cmd_class = `PFPP_OP_SETLK;  // [RQ5]
                `PFPP_CMD_CLRLK:   cmd_class = `PFPP_OP_CLRLK;  // [RQ5]
                `PFPP_CMD_GETLK:   cmd_class = `PFPP_OP_GETLK;  // [RQ5]
                `PFPP_CMD_SETSEC:  cmd_class = `PFPP_OP_SETSEC; // [RQ5]
                `PFPP_CMD_GETSEC:  cmd_class = `PFPP_OP_GETSEC; // [RQ5]
                `PFPP_CMD_SETNV:   cmd_class = `PFPP_OP_SETNV;  // [RQ6]
                `PFPP_CMD_CLRNV:   cmd_class = `PFPP_OP_CLRNV;  // [RQ6]
                `PFPP_CMD_GETNV:   cmd_class = `PFPP_OP_GETNV;  // [RQ6]
                default:           cmd_class = `PFPP_OP_OTHER;  // [RQ6]
            endcase
        end
    endfunction

    // read-type class or the version command means a data handshake reads
    function is_read;
        input [3:0] op;
        begin
            is_read = (op == `PFPP_OP_READ) || (op == `PFPP_OP_GETLK) ||
                      (op == `PFPP_OP_GETSEC) || (op == `PFPP_OP_GETNV) ||
                      (CMD_WORD == `PFPP_CMD_VERSION);
        end
    endfunction

    // =========================================
    // double-flop every pin input
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            meta_r <= 26'h3ffffff;
            sync_r <= 26'h3ffffff;
        end else begin
            meta_r <= {PROG_DATA_IN, FIELD_SELECT, MAIN_CLK_IN,
                       PROG_SELECT_1, PROG_SELECT_0, TEST_SELECT,
                       OUT_ENABLE_N, CMD_STROBE_N};
            sync_r <= meta_r;
        end
    end

    // =========================================
    // external clock presence: two edges in one window
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            xin_d_r     <= 1'b1; // matches sync reset, no false edge
            win_r       <= 16'h0000;
            edges_r     <= 2'h0;
            det_done_r  <= 1'b0;
            EXT_CLK_SEL <= 1'b0; // [RQ15]
        end else if (!det_done_r) begin
            xin_d_r <= main_clk_in;
            if (main_clk_in && !xin_d_r && edges_r != 2'h2)
                edges_r <= edges_r + 2'h1;
            if (win_r == EXT_WIN[15:0]) begin
                win_r       <= 16'h0000;
                edges_r     <= 2'h0;
                EXT_CLK_SEL <= (edges_r == 2'h2); // [RQ14]
            end else begin
                win_r <= win_r + 16'h0001;
            end
            // decision frozen on the cycle after ready first drops
            if (state_r != S_IDLE)
                det_done_r <= 1'b1; // [RQ14]
        end
    end

    // =========================================
    // write words go through the two-entry buffer
    pfpp_buf2 #(.WIDTH(16)) u_wbuf (
        .clk       (CLOCK),
        .rst_b     (RST_B),
        .in_valid  (wr_push_r),
        .in_ready  (wr_in_ready),
        .in_data   (word_r),
        .out_valid (WR_VALID),
        .out_ready (WR_READY),
        .out_data  (WR_DATA)
    );

    // =========================================
    // handshake sequencer
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            state_r       <= S_IDLE;
            sel_r         <= 4'h0;
            word_r        <= 16'h0000;
            addr_hi_r     <= 16'h0000;
            READY_OUT     <= 1'b1;
            READY_OE      <= 1'b0; // [RQ18]
            DATA_VALID_N  <= 1'b1;
            DATA_VALID_OE <= 1'b0; // [RQ18]
            PROG_DATA_OUT <= 16'h0000;
            PROG_DATA_OE  <= 1'b0; // [RQ18]
            CMD_WORD      <= 16'h0000;
            CMD_OP        <= `PFPP_OP_NONE;
            FLASH_ADDR    <= 32'h00000000;
            CMD_START     <= 1'b0;
            FLUSH_REQ     <= 1'b0;
            RD_REQ        <= 1'b0;
            wr_push_r     <= 1'b0;
        end else begin
            CMD_START <= 1'b0;
            FLUSH_REQ <= 1'b0;
            wr_push_r <= 1'b0;
            READY_OE      <= mode_on;
            DATA_VALID_OE <= mode_on;
            case (state_r)
                S_IDLE: begin
                    READY_OUT <= 1'b1; // [RQ13]
                    if (mode_on && !strobe_n) begin
                        sel_r     <= sel;  // [RQ10]
                        word_r    <= din;  // [RQ10]
                        READY_OUT <= 1'b0; // [RQ10]
                        state_r   <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    case (sel_r) // [RQ1]
                        `PFPP_SEL_CMD: begin
                            if (!FLASH_BUSY && !WR_VALID) begin
                                FLUSH_REQ <= 1'b1;   // [RQ21]
                                CMD_WORD  <= word_r; // [RQ2]
                                CMD_OP    <= cmd_class(word_r);
                                CMD_START <= 1'b1;
                                state_r   <= S_WAITS;
                            end
                        end
                        `PFPP_SEL_ADDR_LO: begin
                            FLASH_ADDR <= {addr_hi_r, word_r};
                            state_r    <= S_WAITS;
                        end
                        `PFPP_SEL_ADDR_HI: begin
                            addr_hi_r  <= word_r;
                            FLASH_ADDR <= {word_r, FLASH_ADDR[15:0]};
                            state_r    <= S_WAITS;
                        end
                        `PFPP_SEL_DATA: begin
                            if (is_read(CMD_OP)) begin
                                state_r <= S_WAITO; // [RQ19]
                            end else if (wr_in_ready) begin
                                wr_push_r  <= 1'b1;
                                FLASH_ADDR <= FLASH_ADDR + 32'h1; // [RQ20]
                                state_r    <= S_WAITS;
                            end
                        end
                        default: state_r <= S_WAITS; // [RQ22]
                    endcase
                end
                S_WAITO: begin
                    if (!oe_n) begin
                        RD_REQ  <= 1'b1;
                        state_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (RD_ACK) begin
                        RD_REQ        <= 1'b0;
                        PROG_DATA_OUT <= RD_DATA;
                        PROG_DATA_OE  <= 1'b1;  // [RQ19]
                        state_r       <= S_DRIVE;
                    end
                end
                S_DRIVE: begin
                    DATA_VALID_N <= 1'b0; // [RQ19]
                    if (oe_n && !DATA_VALID_N) begin
                        PROG_DATA_OE <= 1'b0;
                        DATA_VALID_N <= 1'b1; // [RQ19]
                        FLASH_ADDR   <= FLASH_ADDR + 32'h1; // [RQ20]
                        state_r      <= S_WAITS;
                    end
                end
                S_WAITS: begin
                    if (strobe_n) begin
                        READY_OUT <= 1'b1; // [RQ12] [RQ8]
                        state_r   <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// ### verif/pfpp_assertions.sv
// pfpp_assertions.sv: port checker of the programming port
// assumes: bound to pfpp_port; pins pass 2-flop synchronisers
`timescale 1ns/1ps
module pfpp_assertions #(
    parameter EXT_WIN = 16
) (
    // clock and reset
    input wire        CLOCK,
    input wire        RST_B,
    // handshake pins
    input wire        CMD_STROBE_N,
    input wire        OUT_ENABLE_N,
    input wire        READY_OUT,
    input wire        DATA_VALID_N,
    input wire        PROG_DATA_OE,
    input wire        READY_OE,
    input wire        DATA_VALID_OE,
    // flash side
    input wire [15:0] CMD_WORD,
    input wire [3:0]  CMD_OP,
    input wire        CMD_START,
    input wire        FLUSH_REQ
);
    // ==========
    // handshake
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    property p_rdy_fall; $fell(READY_OUT) |-> !$past(CMD_STROBE_N, 2);
    endproperty
    a_rdy_fall: assert property (p_rdy_fall)
        else $error("ready fell without strobe");
    property p_rdy_rise; $rose(READY_OUT) |-> $past(CMD_STROBE_N, 2);
    endproperty
    a_rdy_rise: assert property (p_rdy_rise)
        else $error("ready rose with strobe low");
    property p_rdy_hold; !READY_OUT && !CMD_STROBE_N |=> !READY_OUT;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold)
        else $error("ready rose early");
    property p_flush; CMD_START |-> FLUSH_REQ && !READY_OUT; endproperty
    a_flush: assert property (p_flush)
        else $error("command start without flush");
    // ==========
    // command decode and read bus
    property p_op_read;
        $stable(CMD_WORD) && CMD_WORD == 16'h0011 |-> CMD_OP == 4'h1;
    endproperty
    a_op_read: assert property (p_op_read)
        else $error("read code misdecoded");
    property p_op_ewpp;
        $stable(CMD_WORD) && CMD_WORD == 16'h0042 |-> CMD_OP == 4'h5;
    endproperty
    a_op_ewpp: assert property (p_op_ewpp)
        else $error("erase program protect misdecoded");
    property p_valid; !DATA_VALID_N |-> PROG_DATA_OE; endproperty
    a_valid: assert property (p_valid)
        else $error("valid low with bus not driven");
    property p_oe_rel; PROG_DATA_OE && OUT_ENABLE_N |-> ##[1:4] !PROG_DATA_OE;
    endproperty
    a_oe_rel: assert property (p_oe_rel)
        else $error("bus still driven");
    property p_rst;
        disable iff (1'b0)
        !RST_B |=> !PROG_DATA_OE && !READY_OE && !DATA_VALID_OE &&
            DATA_VALID_N;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pin driven in reset");
    c_cmd: cover property (CMD_START);
    c_read: cover property (!DATA_VALID_N);
    c_stall: cover property ((!READY_OUT && CMD_STROBE_N) [*8]);
endmodule

bind pfpp_port pfpp_assertions #(.EXT_WIN(EXT_WIN)) i_chk (.CLOCK, .RST_B,
    .CMD_STROBE_N, .OUT_ENABLE_N, .READY_OUT, .DATA_VALID_N,
    .PROG_DATA_OE, .READY_OE, .DATA_VALID_OE, .CMD_WORD, .CMD_OP,
    .CMD_START, .FLUSH_REQ);

// ### verif/pfpp_prog_model.sv
// pfpp_prog_model.sv: gang programmer on the handshake pins
// assumes: pins read through pull-ups; drives at falling edges
`timescale 1ns/1ps
module pfpp_prog_model (
    // clock and pin levels
    input  wire         clk,
    input  wire         rdy,
    input  wire         valid_n,
    input  wire  [15:0] bus,
    // programmer drive
    output logic        strobe_n = 1'b1,
    output logic        oe_n = 1'b1,
    output logic [3:0]  sel = 4'hf,
    output logic [15:0] dout = 16'hffff,
    output int          miss = 0
);
    // ==========
    // bounded wait for a pin level
    task automatic wt(input bit on_valid, input logic lvl);
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            if ((on_valid ? valid_n : rdy) === lvl) return;
        end
        miss++;
        $display("mismatch at %0t: programmer wait", $time);
    endtask
    // write handshake; released lines float to pull-up
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        wt(0, 1'b1);
        sel = s;
        dout = d;
        @(negedge clk);
        strobe_n = 1'b0;
        wt(0, 1'b0);
        sel = 4'hf;
        dout = 16'hffff;
        @(negedge clk);
        strobe_n = 1'b1;
        wt(0, 1'b1);
    endtask
    // read handshake
    task automatic rd(output logic [15:0] d);
        wt(0, 1'b1);
        sel = 4'h5;
        @(negedge clk);
        strobe_n = 1'b0;
        wt(0, 1'b0);
        sel = 4'hf;
        oe_n = 1'b0;
        wt(1, 1'b0);
        d = bus;
        oe_n = 1'b1;
        wt(1, 1'b1);
        strobe_n = 1'b1;
        wt(0, 1'b1);
    endtask
endmodule

// ### verif/pfpp_tb_top.sv
// pfpp_tb_top.sv: self-checking bench of the programming port
// assumes: flash side answered here, programmer in pfpp_prog_model
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    error_cnt++; $display("mismatch at %0t: %h not %h", $time, a, b); end end
module pfpp_tb_top;
    logic        clock = 0, rst_b = 0, ext_clk = 0, busy = 0, stall = 0;
    logic        rd_ack = 0, ext_en = 1, tst = 1;
    logic [15:0] rd_data = 0, d;
    logic [15:0] wq [$];
    int          error_cnt = 0, n_compared = 0, rd_cnt = 0;
    wire         ext_sel, rdy, rdy_oe, vld_n, vld_oe, d_oe, start, rd_req;
    wire         stb_n, oe_n, wr_valid;
    wire  [3:0]  sel, op;
    wire  [15:0] d_out, dout, cmd, wr_data;
    wire  [31:0] addr;
    wire  [15:0] bus = d_oe ? d_out : dout;
    // test selects high for the port mode; clock pin may be grounded
    pfpp_port #(.EXT_WIN(16)) i_dut (.CLOCK(clock), .RST_B(rst_b),
        .TEST_SELECT(tst), .PROG_SELECT_0(1'b1),
        .PROG_SELECT_1(1'b1), .MAIN_CLK_IN(ext_clk & ext_en),
        .EXT_CLK_SEL(ext_sel), .CMD_STROBE_N(stb_n),
        .READY_OUT(rdy), .READY_OE(rdy_oe), .OUT_ENABLE_N(oe_n),
        .DATA_VALID_N(vld_n), .DATA_VALID_OE(vld_oe), .FIELD_SELECT(sel),
        .PROG_DATA_IN(bus), .PROG_DATA_OUT(d_out), .PROG_DATA_OE(d_oe),
        .CMD_WORD(cmd), .CMD_OP(op), .FLASH_ADDR(addr), .CMD_START(start),
        .FLUSH_REQ(), .FLASH_BUSY(busy), .WR_VALID(wr_valid),
        .WR_READY(!stall), .WR_DATA(wr_data), .RD_REQ(rd_req),
        .RD_ACK(rd_ack), .RD_DATA(rd_data));
    pfpp_prog_model i_prog (.clk(clock), .rdy(rdy_oe ? rdy : 1'b1),
        .valid_n(vld_oe ? vld_n : 1'b1), .bus(bus), .strobe_n(stb_n),
        .oe_n(oe_n), .sel(sel), .dout(dout), .miss());
    // ==========
    // clocks and flash side
    initial forever #20 clock = ~clock;
    initial forever #80 ext_clk = ~ext_clk;
    always @(posedge clock) if (wr_valid && !stall) wq.push_back(wr_data);
    // slow read answer; data line toggles when idle
    always @(negedge clock) begin
        rd_cnt <= (rd_req && !rd_ack) ? rd_cnt + 1 : 0;
        rd_ack <= rd_req && rd_cnt == 3;
        rd_data <= (rd_req && rd_cnt == 3) ? addr[15:0] ^ 16'ha5a5 : ~rd_data;
    end
    // ==========
    // scenarios
    task automatic t_cmds;
        logic [15:0] c [17] = '{16'h0011, 16'h0012, 16'h0022, 16'h0032,
            16'h0042, 16'h0013, 16'h0014, 16'h0024, 16'h0015, 16'h0054,
            16'h0035, 16'h0034, 16'h0044, 16'h0025, 16'h001f, 16'h0016,
            16'h001e};
        logic [3:0] o [17] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13,
            14, 15, 15, 15};
        for (int i = 0; i < 17; i++) begin
            i_prog.wr(4'h0, c[i]);
            `CHK(cmd, c[i])
            `CHK(op, o[i])
        end
        `CHK(ext_sel, 1'b1)
    endtask
    task automatic t_addr_idle;
        i_prog.wr(4'h2, 16'hbeef);
        i_prog.wr(4'h1, 16'h1234);
        `CHK(addr, 32'hbeef1234)
        for (int s = 3; s < 16; s++) if (s != 5) begin
            i_prog.wr(s[3:0], 16'h0000);
            `CHK({cmd, addr}, {16'h001e, 32'hbeef1234})
        end
    endtask
    // two words fill the buffer, third waits for the drain
    task automatic t_write;
        i_prog.wr(4'h0, 16'h0012);
        i_prog.wr(4'h2, 16'h0000);
        i_prog.wr(4'h1, 16'h0010);
        wq.delete();
        stall = 1;
        i_prog.wr(4'h5, 16'h1111);
        i_prog.wr(4'h5, 16'h2222);
        fork
            i_prog.wr(4'h5, 16'h3333);
            begin
                repeat (60) @(negedge clock);
                `CHK(rdy, 1'b0)
                stall = 0;
            end
        join
        repeat (4) @(negedge clock);
        `CHK({wq[0], wq[1], wq[2]}, 48'h111122223333)
        `CHK(addr, 32'h00000013)
    endtask
    task automatic t_read;
        i_prog.wr(4'h0, 16'h0011);
        i_prog.wr(4'h2, 16'h0000);
        i_prog.wr(4'h1, 16'h0040);
        for (int k = 0; k < 2; k++) begin
            i_prog.rd(d);
            `CHK(d, (16'h0040 + k[15:0]) ^ 16'ha5a5)
        end
        `CHK({d_oe, addr}, {1'b0, 32'h00000042})
    endtask
    // busy flash holds off the new command
    task automatic t_busy;
        busy = 1;
        fork
            i_prog.wr(4'h0, 16'h0013);
            begin
                repeat (40) @(negedge clock);
                `CHK({rdy, op}, 5'h01)
                busy = 0;
            end
        join
        `CHK(op, 4'h6)
    endtask
    // mid-run reset with the clock pin grounded, then test mode off
    task automatic t_reset;
        ext_en = 0;
        rst_b = 0;
        repeat (20) @(negedge clock);
        `CHK({rdy, rdy_oe, vld_oe, d_oe, vld_n}, 5'h11)
        `CHK({ext_sel, addr}, 33'h0)
        rst_b = 1;
        repeat (40) @(negedge clock);
        `CHK({rdy, rdy_oe, ext_sel}, 3'h6)
        i_prog.wr(4'h0, 16'h0011);
        `CHK(op, 4'h1)
        tst = 0;
        repeat (4) @(negedge clock);
        `CHK({rdy_oe, vld_oe}, 2'h0)
        tst = 1;
    endtask
    task automatic results;
        error_cnt += i_prog.miss;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // reset, then the scenarios
    initial begin
        repeat (20) @(posedge clock);
        @(negedge clock) rst_b = 1;
        repeat (40) @(negedge clock);
        t_cmds;
        t_addr_idle;
        t_write;
        t_read;
        t_busy;
        t_reset;
        results;
    end
    initial begin
        #800000;
        error_cnt++;
        results;
    end
endmodule
